// >>> bench/acdp_host_model.sv
// Host sink that stalls the outgoing FIFO and checks each word taken.
`timescale 1ns/1ns
module acdp_host_model (
	input  wire        clock,
	input  wire        rst,
	input  wire        valid,
	input  wire [31:0] data,
	input  wire [31:0] exp_w,
	output wire        ready,
	output int         count,
	output int         bad
);
	logic [1:0] ph_reg;
	// Takes a word on one cycle in four, so the block must hold it.
	assign ready = ph_reg == 2'h3;
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ph_reg <= 2'h0;
			count <= 0;
			bad <= 0;
		end
		else
		begin
			ph_reg <= ph_reg + 2'h1;
			if (valid && ready)
			begin
				count <= count + 1;
				bad <= bad + (data !== exp_w);
			end
		end
	end
endmodule

// >>> bench/acdp_top_checker.sv
// Concurrent checks on the capture block's config and output ports.
`timescale 1ns/1ns
module acdp_top_checker (
	input wire        clock,
	input wire        rst,
	input wire        ce,
	input wire        cfg_wr,
	input wire [2:0]  cfg_addr,
	input wire [7:0]  cfg_data,
	input wire        out_fifo_ready,
	input wire        out_fifo_valid,
	input wire [31:0] out_fifo_data,
	input wire [7:0]  input_fifo_select_reg,
	input wire [7:0]  output_fifo_select_reg,
	input wire        capture_busy_reg
);
	logic [7:0] lo_reg;
	wire        wr = cfg_wr && ce;
	always @(posedge clock or posedge rst)
		if (rst)
			lo_reg <= 8'h00;
		else if (wr && cfg_addr == 3'h2)
			lo_reg <= cfg_data;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_trig;
		wr && cfg_addr == 3'h3 && !capture_busy_reg
			&& {cfg_data[0], lo_reg} != 9'h0;
	endsequence
	AST_IN_SEL: assert property (wr && cfg_addr == 3'h0 |=>
		input_fifo_select_reg == $past(cfg_data)) else $error("in sel");
	AST_OUT_SEL: assert property (wr && cfg_addr == 3'h1 |=>
		output_fifo_select_reg == $past(cfg_data)) else $error("out sel");
	AST_LOW_QUIET: assert property (wr && cfg_addr == 3'h2
		&& !capture_busy_reg |=> !capture_busy_reg) else $error("low");
	AST_TRIG: assert property (s_trig |=> capture_busy_reg)
		else $error("no start");
	AST_FWD: assert property ($rose(capture_busy_reg)
		|-> ##[1:6] out_fifo_valid) else $error("late send");
	AST_HOLD: assert property (out_fifo_valid && !out_fifo_ready
		|=> out_fifo_valid && $stable(out_fifo_data)) else $error("hold");
	AST_PACK: assert property (out_fifo_valid |->
		{out_fifo_data[31:30], out_fifo_data[15:14]} == 4'h0)
		else $error("pack");
	AST_BOUND: assert property ($rose(capture_busy_reg)
		|-> ##[1:520] !capture_busy_reg) else $error("busy long");
endmodule
bind acdp_top acdp_top_checker u_chk (.clock, .rst, .ce, .cfg_wr,
	.cfg_addr, .cfg_data, .out_fifo_ready, .out_fifo_valid,
	.out_fifo_data, .input_fifo_select_reg, .output_fifo_select_reg,
	.capture_busy_reg);

// >>> bench/acdp_top_tb_top.sv
// Self-checking bench for the capture and pattern block.
`timescale 1ns/1ns
module acdp_top_tb_top;
	logic        clock = 0, rst = 1, ce = 1, cfg_wr = 0, in_v = 0;
	logic [2:0]  cfg_addr = 3'h0;
	logic [7:0]  cfg_data = 8'h00;
	logic [11:0] ad = 12'h0, bd = 12'h0;
	logic [3:0]  fl = 4'h0;
	logic [31:0] in_d = 32'h0;
	wire         in_r, ov, busy, rdy;
	wire [31:0]  od;
	wire [7:0]   isel, osel;
	wire [15:0]  da, db;
	int          n_errors = 0, checks_done = 0, cnt, bad;
	wire [31:0]  exp_w = {2'h0, fl[3:2], bd, 2'h0, fl[1:0], ad};
	logic [31:0] frz;
	acdp_top DUT (.clock, .rst, .ce, .cfg_wr, .cfg_addr, .cfg_data,
		.adc_a_data(ad), .adc_a_overrange_flag(fl[0]),
		.adc_a_top_half_used_flag(fl[1]), .adc_b_data(bd),
		.adc_b_overrange_flag(fl[2]), .adc_b_top_half_used_flag(fl[3]),
		.in_fifo_valid(in_v), .in_fifo_data(in_d), .in_fifo_ready(in_r),
		.out_fifo_ready(rdy), .out_fifo_valid(ov), .out_fifo_data(od),
		.input_fifo_select_reg(isel), .output_fifo_select_reg(osel),
		.capture_busy_reg(busy), .dac_a_data(da), .dac_b_data(db));
	// The carrier FIFO side is clocked from the bench clock here.
	acdp_host_model u_host (.clock, .rst, .valid(ov), .data(od), .exp_w,
		.ready(rdy), .count(cnt), .bad);
	initial forever #4 clock = ~clock;
	task chk(input [31:0] s, input [31:0] e);
		checks_done++;
		if (s !== e)
			$display("[ERR] %0t got %h exp %h", $time, s, e);
		if (s !== e)
			n_errors++;
	endtask
	task cfg(input [2:0] a, input [7:0] d);
		@(posedge clock);
		cfg_wr <= 1;
		cfg_addr <= a;
		cfg_data <= d;
		@(posedge clock);
		cfg_wr <= 0;
	endtask
	task cap(input [7:0] lo, input hi, input int n);
		int base;
		base = cnt;
		cfg(3'h2, lo);
		cfg(3'h3, {7'h0, hi});
		for (int k = 0; k < n * 8 + 40 && cnt != base + n; k++)
			@(posedge clock);
		repeat (30) @(posedge clock);
		chk(cnt - base, n);
		chk(bad, 0);
	endtask
	// Sends n pattern words, the first one carrying its own flag nibble.
	task fill(input [3:0] f0, input [3:0] f, input [15:0] o, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clock);
			in_v <= 1;
			in_d <= {2'h3, 10'h0, i == 0 ? f0 : f, 16'(i) | o};
			do @(posedge clock); while (in_r !== 1'b1);
			in_v <= 0;
		end
	endtask
	task sweep(input [15:0] o);
		logic [8:0] p;
		repeat (4) @(posedge clock);
		p = db[8:0];
		repeat (600)
		begin
			@(posedge clock);
			p = p + 9'h1;
			chk(db, {7'h0, p});
			chk(da, {7'h0, p} | o);
		end
	endtask
	task final_report;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 0;
		cfg(3'h0, 8'h5c);
		cfg(3'h1, 8'ha3);
		@(posedge clock);
		chk(isel, 8'h5c);
		chk(osel, 8'ha3);
		chk(in_r, 1'b1);
		ad <= 12'h5a3;
		bd <= 12'h81e;
		fl <= 4'h9;
		cfg(3'h2, 8'h03);
		repeat (10) @(posedge clock);
		chk({busy, ov, cnt[7:0]}, 0);
		cap(8'h03, 1'b0, 3);
		cap(8'h00, 1'b0, 0);
		ad <= 12'h0ff;
		bd <= 12'hf01;
		fl <= 4'h6;
		cap(8'hff, 1'b1, 511);
		fill(4'h1, 4'h1, 16'hdead, 3);
		fill(4'hf, 4'h5, 16'h0, 512);
		sweep(16'h0);
		// Clock enable low must freeze the pattern player.
		@(posedge clock);
		ce <= 0;
		repeat (3) @(posedge clock);
		frz = {da, db};
		repeat (5) @(posedge clock);
		chk({da, db}, frz);
		ce <= 1;
		fill(4'h3, 4'h1, 16'h8000, 512);
		sweep(16'h8000);
		final_report;
	end
	initial
	begin
		repeat (30000) @(posedge clock);
		n_errors++;
		final_report;
	end
endmodule

// >>> include/acdp_defines.vh
// Constants for the converter capture and pattern block.
`ifndef ACDP_DEFINES_VH
`define ACDP_DEFINES_VH
`define ACDP_ADDR_IN_SEL      3'h0
`define ACDP_ADDR_OUT_SEL     3'h1
`define ACDP_ADDR_CNT_LOW     3'h2
`define ACDP_ADDR_CNT_HIGH    3'h3
`define ACDP_FIFO_SEL_RESET   8'h00
`define ACDP_CAP_DEPTH        511
`define ACDP_CAP_AW           9
`define ACDP_PAT_DEPTH        512
`define ACDP_PAT_AW           9
`define ACDP_A_DATA_LSB       0
`define ACDP_A_OVR_BIT        12
`define ACDP_A_TOP_BIT        13
`define ACDP_B_DATA_LSB       16
`define ACDP_B_OVR_BIT        28
`define ACDP_B_TOP_BIT        29
`define ACDP_PAT_DATA_MSB     15
`define ACDP_PAT_WR_A_BIT     16
`define ACDP_PAT_RST_A_BIT    17
`define ACDP_PAT_WR_B_BIT     18
`define ACDP_PAT_RST_B_BIT    19
`define ACDP_CLK_MHZ          100
`endif

// >>> rtl/acdp_ram.v
// Simple dual-port memory with registered read data.
`timescale 1ns/1ns
module acdp_ram #(
	parameter DW    = 16,
	parameter AW    = 9,
	parameter DEPTH = 512
) (
	input  wire          clock,
	input  wire          ce,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:DEPTH-1];

	always @(posedge clock)
	begin
		if (ce)
		begin
			if (wr_en)
				mem[wr_addr] <= wr_data;
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// >>> rtl/acdp_sync.v
// Two-stage synchroniser for a bus of asynchronous levels.
`timescale 1ns/1ns
module acdp_sync #(
	parameter W = 1
) (
	input  wire         clock,
	input  wire         rst,
	input  wire         ce,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta_reg;

	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= {W{1'b0}};
			q        <= {W{1'b0}};
		end
		else if (ce)
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// >>> rtl/acdp_top.v
// Capture buffer, word packer and pattern player for two ADCs and two DACs.
//
// Overview of operation
// - Config address 0 picks the carrier FIFO number read for input.
// - Config address 1 picks the carrier FIFO number written for output.
// - Captured samples wait in a 511-entry buffer of 32-bit words.
// - Low half: A sample 11..0, overrange bit 12, top-half bit 13.
// - High half: B sample 27..16, overrange bit 28, top-half bit 29.
// - Without a capture request nothing is buffered and nothing sent.
// - Forwarding starts at once, while capture is still running.
// - Address 2 write loads low eight count bits without starting.
// - Address 3 write when idle loads count bit eight and starts a capture unless the count is zero.
// - Count gives words captured and sent; it must not exceed 511.
// - Two 512-entry pattern RAMs replay continuously to the DACs.
// - Pattern words carry the DAC value in bits 15..0.
// - Bit 16 writes channel A RAM; bit 18 writes channel B RAM.
// - Bit 17 clears A write pointer; bit 19 clears B pointer.
// - Each write goes to the pointer, which then increments.
// - Both RAMs are read at one shared address in the same cycle.
// - All logic runs from the 100 MHz user oscillator clock.
`timescale 1ns/1ns
`include "acdp_defines.vh"
module acdp_top #(
	parameter CAP_AW = `ACDP_CAP_AW,
	parameter PAT_AW = `ACDP_PAT_AW
) (
	input  wire        clock,
	input  wire        rst,
	input  wire        ce,
	input  wire        cfg_wr,
	input  wire [2:0]  cfg_addr,
	input  wire [7:0]  cfg_data,
	input  wire [11:0] adc_a_data,
	input  wire        adc_a_overrange_flag,
	input  wire        adc_a_top_half_used_flag,
	input  wire [11:0] adc_b_data,
	input  wire        adc_b_overrange_flag,
	input  wire        adc_b_top_half_used_flag,
	input  wire        in_fifo_valid,
	input  wire [31:0] in_fifo_data,
	output reg         in_fifo_ready,
	input  wire        out_fifo_ready,
	output reg         out_fifo_valid,
	output reg  [31:0] out_fifo_data,
	output reg  [7:0]  input_fifo_select_reg,
	output reg  [7:0]  output_fifo_select_reg,
	output reg         capture_busy_reg,
	output reg  [15:0] dac_a_data,
	output reg  [15:0] dac_b_data
);
	localparam CNT_W = CAP_AW;

	// Configuration and capture control state.
	reg [7:0]        count_low_reg;
	reg [CNT_W-1:0]  remaining_reg;
	reg [CNT_W-1:0]  wr_ptr_reg;
	reg [CNT_W-1:0]  rd_ptr_reg;
	reg [CNT_W:0]    level_reg;
	reg              rd_pend_reg;
	reg              hold_valid_reg;

	// ADC pins come from the converter clock and are synchronised first.
	wire [27:0] adc_raw;
	wire [27:0] adc_sync;
	wire [31:0] cap_word;
	wire [31:0] cap_rd_data;

	assign adc_raw = {adc_b_top_half_used_flag, adc_b_overrange_flag,
		adc_b_data, adc_a_top_half_used_flag,
		adc_a_overrange_flag, adc_a_data};

	acdp_sync #(
		.W(28)
	) u_adc_sync (
		.clock (clock),
		.rst   (rst),
		.ce    (ce),
		.d     (adc_raw),
		.q     (adc_sync)
	);

	// Undefined bits 15:14 and 31:30 are driven as zero.
	// They carry no pin, so they are not synchronised.
	assign cap_word = {2'b00, adc_sync[27:14], 2'b00, adc_sync[13:0]};

	// Configuration writes and capture trigger.
	wire cap_push;
	wire cap_pop;
	wire cap_full;

	// A full buffer pauses storing; busy stays high and those samples are lost.
	assign cap_full = (level_reg == `ACDP_CAP_DEPTH);
	assign cap_push = capture_busy_reg && !cap_full;
	// One read is in flight at a time, so a held word is never overwritten.
	assign cap_pop  = (level_reg != 0) && !rd_pend_reg
		&& (!hold_valid_reg || out_fifo_ready);

	// Next state of the capture counter, busy flag and write pointer.
	reg [CNT_W-1:0] remaining_next;
	reg             capture_busy_next;
	reg [CNT_W-1:0] wr_ptr_next;
	wire            cap_trigger;

	// A trigger while a capture runs is ignored; the low byte still loads.
	// The low count byte is kept, so a repeat trigger reuses it.
	assign cap_trigger = cfg_wr && cfg_addr == `ACDP_ADDR_CNT_HIGH
		&& !capture_busy_reg;

	always @*
	begin
		remaining_next    = remaining_reg;
		capture_busy_next = capture_busy_reg;
		wr_ptr_next       = wr_ptr_reg;
		if (cap_push)
		begin
			wr_ptr_next = (wr_ptr_reg == `ACDP_CAP_DEPTH - 1) ?
				{CNT_W{1'b0}} : wr_ptr_reg + 1'b1;
			remaining_next = remaining_reg - 1'b1;
			if (remaining_reg == 1)
				capture_busy_next = 1'b0;
		end
		if (cap_trigger)
		begin
			remaining_next    = {cfg_data[0], count_low_reg};
			capture_busy_next = ({cfg_data[0], count_low_reg} != 0);
		end
	end

	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			input_fifo_select_reg  <= `ACDP_FIFO_SEL_RESET;
			output_fifo_select_reg <= `ACDP_FIFO_SEL_RESET;
			count_low_reg          <= 8'h00;
			remaining_reg          <= {CNT_W{1'b0}};
			capture_busy_reg       <= 1'b0;
			wr_ptr_reg             <= {CNT_W{1'b0}};
		end
		else if (ce)
		begin
			if (cfg_wr && cfg_addr == `ACDP_ADDR_IN_SEL)
				input_fifo_select_reg <= cfg_data;
			if (cfg_wr && cfg_addr == `ACDP_ADDR_OUT_SEL)
				output_fifo_select_reg <= cfg_data;
			if (cfg_wr && cfg_addr == `ACDP_ADDR_CNT_LOW)
				count_low_reg <= cfg_data;
			remaining_reg    <= remaining_next;
			capture_busy_reg <= capture_busy_next;
			wr_ptr_reg       <= wr_ptr_next;
		end
	end

	// Capture buffer memory.
	acdp_ram #(
		.DW    (32),
		.AW    (CAP_AW),
		.DEPTH (`ACDP_CAP_DEPTH)
	) u_cap_ram (
		.clock   (clock),
		.ce      (ce),
		.wr_en   (cap_push),
		.wr_addr (wr_ptr_reg),
		.wr_data (cap_word),
		.rd_addr (rd_ptr_reg),
		.rd_data (cap_rd_data)
	);

	// Drain starts as soon as the first word lands.
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rd_ptr_reg     <= {CNT_W{1'b0}};
			level_reg      <= {(CNT_W+1){1'b0}};
			rd_pend_reg    <= 1'b0;
			hold_valid_reg <= 1'b0;
			out_fifo_valid <= 1'b0;
			out_fifo_data  <= 32'h0000_0000;
		end
		else if (ce)
		begin
			level_reg <= level_reg + {{CNT_W{1'b0}}, cap_push}
				- {{CNT_W{1'b0}}, cap_pop};
			if (cap_pop)
				rd_ptr_reg <= (rd_ptr_reg == `ACDP_CAP_DEPTH - 1) ?
					{CNT_W{1'b0}} : rd_ptr_reg + 1'b1;
			rd_pend_reg <= cap_pop;
			if (out_fifo_valid && out_fifo_ready)
			begin
				out_fifo_valid <= 1'b0;
				hold_valid_reg <= 1'b0;
			end
			if (rd_pend_reg)
			begin
				out_fifo_valid <= 1'b1;
				hold_valid_reg <= 1'b1;
				out_fifo_data  <= cap_rd_data;
			end
		end
	end

	// Pattern write side.
	reg  [PAT_AW-1:0] pat_ptr_a_reg;
	reg  [PAT_AW-1:0] pat_ptr_b_reg;
	reg  [PAT_AW-1:0] play_addr_reg;
	wire              pat_take;
	wire              wr_a;
	wire              wr_b;
	wire [PAT_AW-1:0] addr_a;
	wire [PAT_AW-1:0] addr_b;
	wire [15:0]       pat_val;
	wire [15:0]       ram_a_q;
	wire [15:0]       ram_b_q;

	assign pat_take = in_fifo_valid && in_fifo_ready;
	assign pat_val  = in_fifo_data[`ACDP_PAT_DATA_MSB:0];
	assign wr_a     = pat_take && in_fifo_data[`ACDP_PAT_WR_A_BIT];
	assign wr_b     = pat_take && in_fifo_data[`ACDP_PAT_WR_B_BIT];
	assign addr_a   = in_fifo_data[`ACDP_PAT_RST_A_BIT] ?
		{PAT_AW{1'b0}} : pat_ptr_a_reg;
	assign addr_b   = in_fifo_data[`ACDP_PAT_RST_B_BIT] ?
		{PAT_AW{1'b0}} : pat_ptr_b_reg;

	// A write steps on from the address just used, so a word that carries
	// both reset and select lands at zero and leaves the pointer at one.
	reg  [PAT_AW-1:0] pat_ptr_a_next;
	reg  [PAT_AW-1:0] pat_ptr_b_next;

	always @*
	begin
		pat_ptr_a_next = pat_ptr_a_reg;
		pat_ptr_b_next = pat_ptr_b_reg;
		if (wr_a)
			pat_ptr_a_next = addr_a + 1'b1;
		else if (pat_take && in_fifo_data[`ACDP_PAT_RST_A_BIT])
			pat_ptr_a_next = {PAT_AW{1'b0}};
		if (wr_b)
			pat_ptr_b_next = addr_b + 1'b1;
		else if (pat_take && in_fifo_data[`ACDP_PAT_RST_B_BIT])
			pat_ptr_b_next = {PAT_AW{1'b0}};
	end

	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pat_ptr_a_reg <= {PAT_AW{1'b0}};
			pat_ptr_b_reg <= {PAT_AW{1'b0}};
			play_addr_reg <= {PAT_AW{1'b0}};
			in_fifo_ready <= 1'b0;
			dac_a_data    <= 16'h0000;
			dac_b_data    <= 16'h0000;
		end
		else if (ce)
		begin
			in_fifo_ready <= 1'b1;
			pat_ptr_a_reg <= pat_ptr_a_next;
			pat_ptr_b_reg <= pat_ptr_b_next;
			// The play address runs free over every entry, written or not.
			play_addr_reg <= play_addr_reg + 1'b1;
			// DAC words lag the play address by a RAM read and this flop.
			dac_a_data    <= ram_a_q;
			dac_b_data    <= ram_b_q;
		end
	end

	// Pattern memories share one read address.
	acdp_ram #(
		.DW    (16),
		.AW    (PAT_AW),
		.DEPTH (`ACDP_PAT_DEPTH)
	) u_pat_a (
		.clock   (clock),
		.ce      (ce),
		.wr_en   (wr_a),
		.wr_addr (addr_a),
		.wr_data (pat_val),
		.rd_addr (play_addr_reg),
		.rd_data (ram_a_q)
	);

	acdp_ram #(
		.DW    (16),
		.AW    (PAT_AW),
		.DEPTH (`ACDP_PAT_DEPTH)
	) u_pat_b (
		.clock   (clock),
		.ce      (ce),
		.wr_en   (wr_b),
		.wr_addr (addr_b),
		.wr_data (pat_val),
		.rd_addr (play_addr_reg),
		.rd_data (ram_b_q)
	);
endmodule
